// file: core/agsp_gpio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module agsp_gpio_sync #(
    parameter int DELAY_W = 16,
    parameter int NUM_FAULTS = 4
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port.
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    // Sequencer side.
    input wire logic [1:0] seq_channel_i,
    input wire logic chan_switch_i,
    input wire logic multi_channel_i,
    input wire logic deferred_hold_mode_i,
    input wire logic [DELAY_W-1:0] settle_cycles_i,
    input wire logic [NUM_FAULTS-1:0] status_faults_i,
    input wire logic other_fault_i,
    output logic conv_hold_o,
    output logic conv_start_o,
    output logic converter_fault_o,
    // General pins.
    input wire logic [1:0] general_pin_i,
    output logic [1:0] general_pin_o,
    output logic [1:0] general_pin_oe_o,
    // Sync/fault pin.
    input wire logic sync_fault_pin_i,
    output logic sync_fault_pin_o,
    output logic sync_fault_pin_oe_o
);
    initial begin
        if (DELAY_W < 1 || NUM_FAULTS < 1) begin
            $error("agsp_gpio_sync: widths must be at least one");
        end
    end

    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0] gp_s1;
        logic [1:0] gp_s2;
        logic sf_s1;
        logic sf_s2;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic sf_out;
        logic sf_oe;
        logic hold;
        logic start;
        logic fault;
        agsp_pkg::agsp_state_t state;
        logic [DELAY_W-1:0] count;
    } agsp_regs_t;

    agsp_regs_t r;
    agsp_regs_t next_r;
    logic [1:0] fault_fn;
    logic sync_en;
    logic ext_mux;
    logic deferred;

    assign fault_fn = r.cfg[agsp_pkg::FAULT_FN_LSB +: 2]; // see R7
    assign sync_en = r.cfg[agsp_pkg::SYNC_EN_BIT];
    assign ext_mux = r.cfg[agsp_pkg::EXT_MUX_BIT];
    // A deferred hold without several channels degrades to the plain hold.
    assign deferred = deferred_hold_mode_i && multi_channel_i; // see R6

    always_comb begin
        next_r = r;
        next_r.gp_s1 = general_pin_i;
        next_r.gp_s2 = r.gp_s1;
        next_r.sf_s1 = sync_fault_pin_i;
        next_r.sf_s2 = r.sf_s1;
        next_r.start = 1'b0;
        if (cfg_wr_i) begin
            next_r.cfg = cfg_wdata_i & agsp_pkg::CFG_WRITE_MASK; // see R19
        end
        // Two pins encode the channel index, which caps steering at four.
        if (ext_mux) begin
            next_r.pin_out = seq_channel_i; // see R1, R2
            next_r.pin_oe = 2'h3;
        end else begin
            next_r.pin_out = {next_r.cfg[agsp_pkg::PIN1_LEVEL_BIT], next_r.cfg[agsp_pkg::PIN0_LEVEL_BIT]};
            next_r.pin_oe[1] = next_r.cfg[agsp_pkg::PIN1_OUT_EN_BIT] && !next_r.cfg[agsp_pkg::PIN1_IN_EN_BIT]; // see R15, R13
            next_r.pin_oe[0] = next_r.cfg[agsp_pkg::PIN0_OUT_EN_BIT] && !next_r.cfg[agsp_pkg::PIN0_IN_EN_BIT]; // see R16, R14
        end
        // Input pins overwrite their data bits with the sampled level.
        if (r.cfg[agsp_pkg::PIN1_IN_EN_BIT] && !cfg_wr_i) begin
            next_r.cfg[agsp_pkg::PIN1_LEVEL_BIT] = r.gp_s2[1]; // see R17
        end
        if (r.cfg[agsp_pkg::PIN0_IN_EN_BIT] && !cfg_wr_i) begin
            next_r.cfg[agsp_pkg::PIN0_LEVEL_BIT] = r.gp_s2[0]; // see R18
        end
        if (fault_fn == agsp_pkg::FAULT_IN && !cfg_wr_i) begin
            next_r.cfg[agsp_pkg::FAULT_LEVEL_BIT] = r.sf_s2; // see R8, R12
        end
        next_r.fault = other_fault_i || (fault_fn == agsp_pkg::FAULT_IN && !r.sf_s2); // see R8
        unique case (next_r.cfg[agsp_pkg::FAULT_FN_LSB +: 2])
            agsp_pkg::FAULT_OD: begin
                // Open drain only ever pulls low, so devices can share the line.
                next_r.sf_out = 1'b0;
                next_r.sf_oe = |status_faults_i; // see R9
            end
            agsp_pkg::FAULT_GPO: begin
                next_r.sf_out = next_r.cfg[agsp_pkg::FAULT_LEVEL_BIT]; // see R10, R11, R12
                next_r.sf_oe = 1'b1;
            end
            default: begin
                next_r.sf_out = 1'b0;
                next_r.sf_oe = 1'b0;
            end
        endcase
        next_r.hold = sync_en && !deferred && !r.sf_s2; // see R4
        unique case (r.state)
            agsp_pkg::AGSP_RUN: begin
                if (chan_switch_i) begin
                    if (ext_mux && settle_cycles_i != '0) begin
                        next_r.count = settle_cycles_i; // see R3
                        next_r.state = agsp_pkg::AGSP_SETTLE;
                    end else if (sync_en && deferred && !r.sf_s2) begin
                        next_r.state = agsp_pkg::AGSP_WAIT_SYNC; // see R5
                    end else begin
                        next_r.start = 1'b1;
                    end
                end
            end
            agsp_pkg::AGSP_SETTLE: begin
                next_r.count = r.count - 1'b1;
                if (r.count == DELAY_W'(1)) begin
                    if (sync_en && deferred && !r.sf_s2) begin
                        next_r.state = agsp_pkg::AGSP_WAIT_SYNC;
                    end else begin
                        next_r.state = agsp_pkg::AGSP_RUN;
                        next_r.start = 1'b1;
                    end
                end
            end
            agsp_pkg::AGSP_WAIT_SYNC: begin
                if (r.sf_s2 || !sync_en || !deferred) begin
                    next_r.state = agsp_pkg::AGSP_RUN; // see R5
                    next_r.start = 1'b1;
                end
            end
            default: begin
                // The fourth code of the state word is unused; fall back to running.
                next_r.state = agsp_pkg::AGSP_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.cfg <= agsp_pkg::CFG_RESET; // see R4, R7
            r.gp_s1 <= 2'h0;
            r.state <= agsp_pkg::AGSP_RUN;
        end else begin
            r <= next_r;
        end
    end

    assign cfg_rdata_o = r.cfg;
    assign general_pin_o = r.pin_out;
    assign general_pin_oe_o = r.pin_oe;
    assign sync_fault_pin_o = r.sf_out;
    assign sync_fault_pin_oe_o = r.sf_oe;
    assign conv_hold_o = r.hold;
    assign conv_start_o = r.start;
    assign converter_fault_o = r.fault;
endmodule // agsp_gpio_sync
`default_nettype wire

// file: core/agsp_pkg.sv
// Behaviour
// R1 - Mux steering bit makes both general pins follow the sequencer channel index.
// R2 - Sequencer steers at most four channels, so two pins carry the index.
// R3 - After each external mux switch, wait the configured settling delay before converting.
// R4 - Sync input enabled (reset one): low pin holds modulator and filter in reset.
// R5 - Deferred hold: low pin at channel switch blocks next conversion until pin high.
// R6 - Deferred hold acts only with several channels enabled, else ordinary sync hold.
// R7 - Two-bit fault-pin function field; zero disables, resets to zero.
// R8 - Fault input: inverted pin ORed into converter fault flag; level bit shows pin.
// R9 - Open-drain fault output: ORed status faults, inverted, drive the shared line.
// R10 - General output role drives pin high or low from the level bit, push-pull.
// R11 - Function code three selects the general-purpose output role.
// R12 - Level bit sets output level, reads back sampled pin when an input.
// R13 - Pin one input enable bit makes pin one an input; resets zero.
// R14 - Pin zero input enable bit makes pin zero an input; resets zero.
// R15 - Pin one output enable bit drives pin one; resets zero.
// R16 - Pin zero output enable bit drives pin zero; resets zero.
// R17 - Pin one data bit is driven level when output, sampled level when input.
// R18 - Pin zero data bit is driven level when output, sampled level when input.
// R19 - Software writes zero to bits seven and six; device reads them as zero.
package agsp_pkg;
    localparam logic [15:0] CFG_RESET = 16'h0800;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h1f3f;
    localparam int EXT_MUX_BIT = 12;
    localparam int SYNC_EN_BIT = 11;
    localparam int FAULT_FN_LSB = 9;
    localparam int FAULT_LEVEL_BIT = 8;
    localparam int PIN1_IN_EN_BIT = 5;
    localparam int PIN0_IN_EN_BIT = 4;
    localparam int PIN1_OUT_EN_BIT = 3;
    localparam int PIN0_OUT_EN_BIT = 2;
    localparam int PIN1_LEVEL_BIT = 1;
    localparam int PIN0_LEVEL_BIT = 0;
    localparam logic [1:0] FAULT_OFF = 2'h0;
    localparam logic [1:0] FAULT_IN = 2'h1;
    localparam logic [1:0] FAULT_OD = 2'h2;
    localparam logic [1:0] FAULT_GPO = 2'h3;
    localparam int MAX_SEQ_CHANNELS = 4;
    typedef enum logic [1:0] {
        AGSP_RUN,
        AGSP_SETTLE,
        AGSP_WAIT_SYNC
    } agsp_state_t;
endpackage

// file: verif/adc_gpio_sync_error_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_gpio_sync_error_ctrl_tb;
    logic mclk_i = 1'b0, resetn_i = 1'b0, cfg_wr_i = 1'b0, chan_switch_i = 1'b0, multi_channel_i = 1'b1;
    logic deferred_hold_mode_i = 1'b0, other_fault_i = 1'b0, ext_pull_low = 1'b0, conv_hold_o, conv_start_o;
    logic converter_fault_o, sync_fault_pin_i, sync_fault_pin_o, sync_fault_pin_oe_o;
    logic [1:0] seq_channel_i = 2'h0, ext_level = 2'h3, general_pin_i, general_pin_o, general_pin_oe_o;
    logic [3:0] status_faults_i = 4'h0;
    logic [15:0] cfg_wdata_i = 16'h0000, settle_cycles_i = 16'h0000, cfg_rdata_o;
    int n_fail = 0, tests_run = 0, n, starts = 0;
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", what, exp, got); end end
    always #10 mclk_i = ~mclk_i;
    always @(negedge mclk_i) starts += conv_start_o;
    agsp_gpio_sync uut (.*);
    agsp_pin_env env (.ext_level_i(ext_level), .ext_pull_low_i(ext_pull_low), .*);
    task automatic idle();
        repeat (5) @(negedge mclk_i);
    endtask
    task automatic wr(input logic [15:0] d);
        cfg_wr_i = 1'b1;
        cfg_wdata_i = d;
        @(negedge mclk_i) cfg_wr_i = 1'b0;
        idle();
    endtask
    task automatic switch_start();
        chan_switch_i = 1'b1;
        @(negedge mclk_i) chan_switch_i = 1'b0;
        for (n = 0; !conv_start_o && n < 12; n++) @(negedge mclk_i);
        if (n == 12) begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic t_regs();
        `CHK("reset value", 16'h0800, cfg_rdata_o)
        wr(16'h0f3f);
        `CHK("masked readback", 16'h0f3f, cfg_rdata_o)
        `CHK("pin drive", 4'h3, {general_pin_oe_o, sync_fault_pin_oe_o, sync_fault_pin_i})
        wr(16'h0e00);
        `CHK("low output holds", 2'h1, {sync_fault_pin_i, conv_hold_o})
        $display("t_regs done");
    endtask
    task automatic t_pins();
        wr(16'h000e);
        `CHK("outputs", 5'h1c, {general_pin_oe_o, general_pin_o, sync_fault_pin_oe_o})
        ext_level = 2'h1;
        wr(16'h0030);
        `CHK("input readback", 16'h0031, cfg_rdata_o)
        wr(16'h1000);
        for (int c = 0; c < 4; c++) begin
            seq_channel_i = c[1:0];
            repeat (2) @(negedge mclk_i);
            `CHK("mux select", c[1:0], general_pin_o)
        end
        $display("t_pins done");
    endtask
    task automatic t_fault();
        ext_pull_low = 1'b1;
        wr(16'h0200);
        `CHK("fault low", 2'h2, {converter_fault_o, cfg_rdata_o[8]})
        ext_pull_low = 1'b0;
        idle();
        `CHK("fault high", 2'h1, {converter_fault_o, cfg_rdata_o[8]})
        status_faults_i = 4'h8;
        wr(16'h0400);
        `CHK("open drain fault", 1'b0, sync_fault_pin_i)
        status_faults_i = 4'h0;
        idle();
        `CHK("open drain idle", 2'h1, {sync_fault_pin_oe_o, sync_fault_pin_i})
        $display("t_fault done");
    endtask
    task automatic t_seq();
        wr(16'h1800);
        settle_cycles_i = 16'h0003;
        switch_start();
        `CHK("settle wait", 3, n)
        settle_cycles_i = 16'h0000;
        deferred_hold_mode_i = 1'b1;
        ext_pull_low = 1'b1;
        idle();
        `CHK("no early hold", 1'b0, conv_hold_o)
        n = starts;
        chan_switch_i = 1'b1;
        @(negedge mclk_i) chan_switch_i = 1'b0;
        idle();
        `CHK("held start", n, starts)
        ext_pull_low = 1'b0;
        for (n = 0; !conv_start_o && n < 12; n++) @(negedge mclk_i);
        `CHK("release start", 3, n)
        multi_channel_i = 1'b0;
        ext_pull_low = 1'b1;
        idle();
        `CHK("single channel hold", 1'b1, conv_hold_o)
        $display("t_seq done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        t_regs();
        t_pins();
        t_fault();
        t_seq();
        complete_run();
    end
endmodule // adc_gpio_sync_error_ctrl_tb
`default_nettype wire

// file: verif/agsp_gpio_sync_props.sv
`timescale 1ns/1ps
`default_nettype none
module agsp_gpio_sync_props #(parameter int NUM_FAULTS = 4) (
    // Clock and control side.
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic [1:0] seq_channel_i,
    input wire logic multi_channel_i,
    input wire logic deferred_hold_mode_i,
    input wire logic [NUM_FAULTS-1:0] status_faults_i,
    input wire logic conv_hold_o,
    input wire logic converter_fault_o,
    // Pins.
    input wire logic [1:0] general_pin_o,
    input wire logic [1:0] general_pin_oe_o,
    input wire logic sync_fault_pin_i,
    input wire logic sync_fault_pin_o,
    input wire logic sync_fault_pin_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    chk_reserved_zero: assert property (cfg_rdata_o[15:13] == 3'h0 && cfg_rdata_o[7:6] == 2'h0)
        else $error("reserved bits set");
    chk_write_fields: assert property (
        cfg_wr_i |=> cfg_rdata_o[12:9] == $past(cfg_wdata_i[12:9]) && cfg_rdata_o[5:2] == $past(cfg_wdata_i[5:2]))
        else $error("config write lost");
    chk_mux_follow: assert property (
        cfg_rdata_o[12] && $stable(cfg_rdata_o[12]) |-> general_pin_oe_o == 2'h3 && general_pin_o == $past(seq_channel_i))
        else $error("mux pins off");
    chk_gpo_drive: assert property (
        cfg_rdata_o[10:9] == 2'h3 && $stable(cfg_rdata_o) |-> sync_fault_pin_oe_o && sync_fault_pin_o == cfg_rdata_o[8])
        else $error("general output drive off");
    chk_od_drive: assert property (
        cfg_rdata_o[10:9] == 2'h2 && $stable(cfg_rdata_o) && $stable(status_faults_i)
        |-> sync_fault_pin_oe_o == (|status_faults_i) && !(sync_fault_pin_oe_o && sync_fault_pin_o))
        else $error("open drain drive off");
    chk_fault_in: assert property (
        (cfg_rdata_o[10:9] == 2'h1 && !sync_fault_pin_i)[*5] |-> converter_fault_o && !cfg_rdata_o[8])
        else $error("fault input not seen");
    chk_sync_hold: assert property (
        (cfg_rdata_o[11] && !(deferred_hold_mode_i && multi_channel_i) && !sync_fault_pin_i)[*5] |-> conv_hold_o)
        else $error("hold missing");
    chk_sync_free: assert property (sync_fault_pin_i[*5] |-> !conv_hold_o)
        else $error("hold with pin high");
endmodule // agsp_gpio_sync_props
bind agsp_gpio_sync agsp_gpio_sync_props #(.NUM_FAULTS(NUM_FAULTS)) u_props (.*);
`default_nettype wire

// file: verif/agsp_pin_env.sv
`timescale 1ns/1ps
`default_nettype none
module agsp_pin_env (
    // Device drive.
    input wire logic [1:0] general_pin_o,
    input wire logic [1:0] general_pin_oe_o,
    input wire logic sync_fault_pin_o,
    input wire logic sync_fault_pin_oe_o,
    // Far side and resolved lines.
    input wire logic [1:0] ext_level_i,
    input wire logic ext_pull_low_i,
    output logic [1:0] general_pin_i,
    output logic sync_fault_pin_i
);
    // The shared line has a pull-up, so any device sinking it wins over it.
    assign sync_fault_pin_i = (sync_fault_pin_oe_o ? sync_fault_pin_o : 1'b1) & ~ext_pull_low_i;
    assign general_pin_i = (general_pin_oe_o & general_pin_o) | (~general_pin_oe_o & ext_level_i);
endmodule // agsp_pin_env
`default_nettype wire
